// file: core/dacr_pkg.sv
`default_nettype none
// ======================================================================
// Shared constants and types of the driver and algorithm config bank.
package dacr_pkg;
  // Bus widths; the byte address is four times the register index.
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  // Register indices as printed; byte address = index * 4.
  localparam logic [7:0] IDX_ALGO_ONE = 8'hA0;
  localparam logic [7:0] IDX_ALGO_TWO = 8'hA2;
  localparam logic [7:0] IDX_GD_TWO = 8'hAE;
  // Field positions of gate_driver_config_two.
  localparam int PARITY_BIT = 31;
  localparam int COMP_EN_BIT = 30;
  localparam int TDLY_MSB = 29;
  localparam int TDLY_LSB = 26;
  localparam int SEQ_OFF_BIT = 24;
  localparam int LIMIT_BIT = 23;
  localparam int VSEL_MSB = 22;
  localparam int VSEL_LSB = 21;
  localparam int REGOFF_BIT = 20;
  localparam int MINON_MSB = 19;
  localparam int MINON_LSB = 17;
  // Reset values of the fields that do not reset to zero.
  localparam logic SEQ_OFF_RST = 1'h1;
  localparam logic [1:0] VSEL_RST = 2'h1;
  // Implemented widths of the algorithm words (bits above read zero).
  localparam int ALGO_ONE_W = 31;
  localparam int ALGO_TWO_W = 10;
  // Clock rate and period.
  localparam int CLK_MHZ = 50;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // Edge rate codes; codes 0 and 1 are reserved.
  localparam logic [1:0] SLEW_125 = 2'h2;
  localparam logic [1:0] SLEW_200 = 2'h3;
  localparam logic [3:0] TDLY_AUTO = 4'h0;
  localparam logic [2:0] MINON_AUTO = 3'h1;
  // Automatic targets per edge rate; values are arbitrary defaults.
  localparam int AUTO_DLY_125_NS = 1200;
  localparam int AUTO_DLY_200_NS = 800;
  localparam int AUTO_MINON_125_NS = 1000;
  localparam int AUTO_MINON_200_NS = 750;
  // Decode tables in ns, mV and mA.
  localparam int TDLY_NS [16] = '{0, 400, 600, 800, 1000, 1200, 1400, 1600,
                                  1800, 2000, 2200, 2400, 2600, 2800, 3000, 3200};
  localparam int MINON_NS [8] = '{0, 0, 500, 750, 1000, 1250, 1500, 2000};
  localparam int BUCK_MV [4] = '{3300, 5000, 4000, 5700};
  localparam int LIMIT_MA [2] = '{600, 150};
  // Result types.
  typedef logic [7:0] dacr_dly_cyc_type;
  typedef logic [6:0] dacr_minon_cyc_type;
  typedef logic [12:0] dacr_mv_type;
  typedef logic [9:0] dacr_ma_type;
  // Register selected by an address.
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00, SEL_ALGO1 = 2'b01, SEL_ALGO2 = 2'b10, SEL_GD2 = 2'b11
  } dacr_sel_type;
endpackage : dacr_pkg
`default_nettype wire

// file: core/dacr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Field codes out to the decoder and decoded settings back.
interface dacr_cfg_if;
  logic [3:0] delay_target_code; // Delay target code.
  logic [2:0] min_on_code;       // Low-side minimum on-time code.
  logic [1:0] voltage_code;      // Regulator voltage code.
  logic limit_code;              // Regulator limit select.
  logic [1:0] slew_code;         // Output edge rate code.
  dacr_pkg::dacr_dly_cyc_type delay_cycles;
  dacr_pkg::dacr_minon_cyc_type min_on_cycles;
  dacr_pkg::dacr_mv_type voltage_mv;
  dacr_pkg::dacr_ma_type limit_ma;
  logic slew_reserved;           // Edge rate code is reserved.
  modport regs (output delay_target_code, min_on_code, voltage_code, limit_code,
                slew_code, input delay_cycles, min_on_cycles, voltage_mv,
                limit_ma, slew_reserved);
  modport decode (input delay_target_code, min_on_code, voltage_code, limit_code,
                  slew_code, output delay_cycles, min_on_cycles, voltage_mv,
                  limit_ma, slew_reserved);
endinterface : dacr_cfg_if
`default_nettype wire

// file: core/dacr_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Turns field codes into registered cycle counts, millivolts and mA.
module dacr_decode (
  input wire logic ref_clk,
  input wire logic reset_n,
  dacr_cfg_if.decode cfg
);
  // Least times round up to whole clock cycles.
  function automatic int ns_to_cycles(input int ns);
    ns_to_cycles = (ns + dacr_pkg::CLK_PERIOD_NS - 1) / dacr_pkg::CLK_PERIOD_NS;
  endfunction : ns_to_cycles

  // Reserved edge rates fall back to the slower setting.
  function automatic int auto_pick(input logic [1:0] s, input int f, input int sl);
    auto_pick = (s == dacr_pkg::SLEW_200) ? f : sl;
  endfunction : auto_pick

  // Delay target, with the automatic code following the edge rate.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg.delay_cycles <= '0;
    end else if (cfg.delay_target_code == dacr_pkg::TDLY_AUTO) begin
      cfg.delay_cycles <= dacr_pkg::dacr_dly_cyc_type'(ns_to_cycles(auto_pick(
        cfg.slew_code, dacr_pkg::AUTO_DLY_200_NS, dacr_pkg::AUTO_DLY_125_NS)));
    end else begin
      cfg.delay_cycles <= dacr_pkg::dacr_dly_cyc_type'(
        ns_to_cycles(dacr_pkg::TDLY_NS[cfg.delay_target_code]));
    end
  end

  // Minimum on-time; code zero means no minimum at all.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg.min_on_cycles <= '0;
    end else if (cfg.min_on_code == dacr_pkg::MINON_AUTO) begin
      cfg.min_on_cycles <= dacr_pkg::dacr_minon_cyc_type'(ns_to_cycles(auto_pick(
        cfg.slew_code, dacr_pkg::AUTO_MINON_200_NS, dacr_pkg::AUTO_MINON_125_NS)));
    end else begin
      cfg.min_on_cycles <= dacr_pkg::dacr_minon_cyc_type'(
        ns_to_cycles(dacr_pkg::MINON_NS[cfg.min_on_code]));
    end
  end

  // Regulator voltage, current limit and edge rate check.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg.voltage_mv <= '0;
      cfg.limit_ma <= '0;
      cfg.slew_reserved <= 1'b0;
    end else begin
      cfg.voltage_mv <= dacr_pkg::dacr_mv_type'(dacr_pkg::BUCK_MV[cfg.voltage_code]);
      cfg.limit_ma <= dacr_pkg::dacr_ma_type'(dacr_pkg::LIMIT_MA[cfg.limit_code]);
      cfg.slew_reserved <= (cfg.slew_code != dacr_pkg::SLEW_125) &&
                           (cfg.slew_code != dacr_pkg::SLEW_200);
    end
  end

  // Checks on the decoded values.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_top_delay_code: assert property (
    cfg.delay_target_code == 4'hF |=> cfg.delay_cycles == 8'hA0)
    else $error("delay code F is not 160 cycles");
  a_voltage_code: assert property (
    cfg.voltage_code == 2'h3 |=> cfg.voltage_mv == 13'h1644)
    else $error("voltage code 3 is not 5700 mV");
  a_min_on_round: assert property (
    cfg.min_on_code == 3'h3 |=> cfg.min_on_cycles == 7'h26)
    else $error("0.75 us on-time not rounded up to 38");
  a_slew_auto_fast: assert property (
    (cfg.min_on_code == 3'h1 && cfg.slew_code == 2'h3) |=>
      cfg.min_on_cycles == 7'h26 && !cfg.slew_reserved)
    else $error("auto on-time at 200 V/us wrong");
endmodule : dacr_decode
`default_nettype wire

// file: core/dacr_regs.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Register bank for the second gate-driver word and the algorithm words.
module dacr_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [9:0] bus_addr,
  input wire logic [31:0] bus_wr_data,
  input wire logic bus_wr_en,
  input wire logic bus_rd_en,
  output logic [31:0] bus_rd_data,
  input wire logic [1:0] slew_rate_code,
  output logic parity_bit,
  output logic delay_comp_en,
  output logic [7:0] delay_target_cycles,
  output logic [6:0] min_on_cycles,
  output logic regulator_sequencing_off,
  output logic regulator_limit_select,
  output logic [9:0] regulator_limit_ma,
  output logic [12:0] regulator_voltage_mv,
  output logic regulator_off,
  output logic edge_rate_reserved,
  output logic [30:0] algorithm_config_one_bits,
  output logic [9:0] algorithm_config_two_bits
);

  // ======================================================================
  // Storage.

  // Stored fields of gate_driver_config_two.
  logic parity_r;
  logic comp_en_r;
  logic [3:0] tdly_r;
  logic seq_off_r;
  logic limit_r;
  logic [1:0] vsel_r;
  logic regoff_r;
  logic [2:0] minon_r;
  // Writable bits of the two algorithm words.
  logic [dacr_pkg::ALGO_ONE_W-1:0] algo_one_r;
  logic [dacr_pkg::ALGO_TWO_W-1:0] algo_two_r;
  // Registered read answer.
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;
  // Decoded strobes.
  dacr_pkg::dacr_sel_type sel;
  logic wr_gd2;
  logic wr_algo1;
  logic wr_algo2;

  // Link to the field decoder.
  dacr_cfg_if cfg ();

  // ======================================================================
  // Address decode.

  // Maps a byte address to a register; misaligned addresses map nowhere.
  // Used by both the write and the read path so the two never disagree.
  function automatic dacr_pkg::dacr_sel_type reg_select(
    input logic [9:0] a
  );
    logic [7:0] idx;
    idx = a[9:2];
    reg_select = dacr_pkg::SEL_NONE;
    if (a[1:0] == 2'h0) begin
      if (idx == dacr_pkg::IDX_ALGO_ONE) begin
        reg_select = dacr_pkg::SEL_ALGO1;
      end else if (idx == dacr_pkg::IDX_ALGO_TWO) begin
        reg_select = dacr_pkg::SEL_ALGO2;
      end else if (idx == dacr_pkg::IDX_GD_TWO) begin
        reg_select = dacr_pkg::SEL_GD2;
      end
    end
  endfunction : reg_select

  // Reserved offsets decode to none, so writes there change nothing.
  // reserved offsets ignored
  assign sel = reg_select(bus_addr);
  assign wr_gd2 = bus_wr_en && (sel == dacr_pkg::SEL_GD2);
  assign wr_algo1 = bus_wr_en && (sel == dacr_pkg::SEL_ALGO1);
  assign wr_algo2 = bus_wr_en && (sel == dacr_pkg::SEL_ALGO2);

  // ======================================================================
  // Gate-driver word fields.

  // Parity bit is plain storage; the bank does not check it.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      parity_r <= 1'b0;
    end else if (wr_gd2) begin
      parity_r <= bus_wr_data[dacr_pkg::PARITY_BIT];
    end
  end

  // Compensation enable and its delay target.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      comp_en_r <= 1'b0;
      tdly_r <= 4'h0;
    end else if (wr_gd2) begin
      comp_en_r <= bus_wr_data[dacr_pkg::COMP_EN_BIT];
      tdly_r <= bus_wr_data[dacr_pkg::TDLY_MSB:dacr_pkg::TDLY_LSB];
    end
  end

  // Sequencing off can only be cleared; nothing in the bank sets it
  // again, so only a reset brings it back to one.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_off_r <= dacr_pkg::SEQ_OFF_RST;
    end else if (wr_gd2 && bus_wr_data[dacr_pkg::SEQ_OFF_BIT]) begin
      seq_off_r <= 1'b0;
    end
  end

  // Regulator limit, voltage and off controls.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_r <= 1'b0;
      vsel_r <= dacr_pkg::VSEL_RST;
      regoff_r <= 1'b0;
    end else if (wr_gd2) begin
      limit_r <= bus_wr_data[dacr_pkg::LIMIT_BIT];
      vsel_r <= bus_wr_data[dacr_pkg::VSEL_MSB:dacr_pkg::VSEL_LSB];
      regoff_r <= bus_wr_data[dacr_pkg::REGOFF_BIT];
    end
  end

  // Low-side minimum on-time code.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      minon_r <= 3'h0;
    end else if (wr_gd2) begin
      minon_r <= bus_wr_data[dacr_pkg::MINON_MSB:dacr_pkg::MINON_LSB];
    end
  end

  // ======================================================================
  // Algorithm words.

  // The top bit of the first word is not stored at all, so it reads zero.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      algo_one_r <= '0;
    end else if (wr_algo1) begin
      algo_one_r <= bus_wr_data[dacr_pkg::ALGO_ONE_W-1:0];
    end
  end

  // Only the low bits of the second word are implemented.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      algo_two_r <= '0;
    end else if (wr_algo2) begin
      algo_two_r <= bus_wr_data[dacr_pkg::ALGO_TWO_W-1:0];
    end
  end

  // ======================================================================
  // Read path.

  // Builds the read word; unstored bits stay zero.
  always_comb begin
    rd_data_nxt = '0;
    unique case (sel)
      dacr_pkg::SEL_GD2: begin
        rd_data_nxt[dacr_pkg::PARITY_BIT] = parity_r;
        rd_data_nxt[dacr_pkg::COMP_EN_BIT] = comp_en_r;
        rd_data_nxt[dacr_pkg::TDLY_MSB:dacr_pkg::TDLY_LSB] = tdly_r;
        rd_data_nxt[dacr_pkg::SEQ_OFF_BIT] = seq_off_r;
        rd_data_nxt[dacr_pkg::LIMIT_BIT] = limit_r;
        rd_data_nxt[dacr_pkg::VSEL_MSB:dacr_pkg::VSEL_LSB] = vsel_r;
        rd_data_nxt[dacr_pkg::REGOFF_BIT] = regoff_r;
        rd_data_nxt[dacr_pkg::MINON_MSB:dacr_pkg::MINON_LSB] = minon_r;
      end
      dacr_pkg::SEL_ALGO1: begin
        rd_data_nxt[dacr_pkg::ALGO_ONE_W-1:0] = algo_one_r;
      end
      dacr_pkg::SEL_ALGO2: begin
        rd_data_nxt[dacr_pkg::ALGO_TWO_W-1:0] = algo_two_r;
      end
      dacr_pkg::SEL_NONE: begin
        // Unmapped and reserved offsets answer zero.
        rd_data_nxt = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= '0;
    end else if (bus_rd_en) begin
      rd_data_r <= rd_data_nxt;
    end else begin
      rd_data_r <= '0;
    end
  end

  // ======================================================================
  // Decoder and outputs.

  // Field codes go to the decoder, which registers its results.
  assign cfg.delay_target_code = tdly_r;
  assign cfg.min_on_code = minon_r;
  assign cfg.voltage_code = vsel_r;
  assign cfg.limit_code = limit_r;
  // The edge rate comes from logic on this clock, so no synchroniser.
  // edge rate feeds decode
  assign cfg.slew_code = slew_rate_code;

  // Decoder instance; one cycle of latency behind the fields.
  dacr_decode i_dacr_decode (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg(cfg.decode)
  );

  // Every output below is a flip-flop of this bank or of the decoder.
  assign bus_rd_data = rd_data_r;
  assign parity_bit = parity_r;
  assign delay_comp_en = comp_en_r;
  assign delay_target_cycles = cfg.delay_cycles;
  assign min_on_cycles = cfg.min_on_cycles;
  assign regulator_sequencing_off = seq_off_r;
  assign regulator_limit_select = limit_r;
  assign regulator_limit_ma = cfg.limit_ma;
  assign regulator_voltage_mv = cfg.voltage_mv;
  assign regulator_off = regoff_r;
  assign edge_rate_reserved = cfg.slew_reserved;
  assign algorithm_config_one_bits = algo_one_r;
  assign algorithm_config_two_bits = algo_two_r;

  // ======================================================================
  // Checks.

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // A write to the first algorithm word followed by a read of it.
  sequence s_algo1_write;
    wr_algo1;
  endsequence
  sequence s_algo1_read;
    bus_rd_en && (sel == dacr_pkg::SEL_ALGO1);
  endsequence

  // A read of the gate word.
  sequence s_gd2_read;
    bus_rd_en && (sel == dacr_pkg::SEL_GD2);
  endsequence

  // A read of the second algorithm word.
  sequence s_algo2_read;
    bus_rd_en && (sel == dacr_pkg::SEL_ALGO2);
  endsequence

  a_comp_en_follows: assert property (
    wr_gd2 |=> delay_comp_en == $past(bus_wr_data[30]))
    else $error("compensation enable did not follow write");
  a_target_readback: assert property (
    (wr_gd2 ##1 s_gd2_read) |=> bus_rd_data[29:26] == $past(bus_wr_data[29:26], 2))
    else $error("delay target did not read back");
  a_seq_clear_once: assert property (
    (wr_gd2 && bus_wr_data[24]) |=> !regulator_sequencing_off [*2])
    else $error("sequencing off not cleared or set again");
  a_seq_zero_write: assert property (
    (wr_gd2 && !bus_wr_data[24]) |=> $stable(regulator_sequencing_off))
    else $error("zero write changed sequencing off");
  a_limit_to_ma: assert property (
    (wr_gd2 && bus_wr_data[23]) |=> ##1 regulator_limit_ma == 10'h096)
    else $error("limit select 1 is not 150 mA");
  a_regoff_follows: assert property (
    wr_gd2 |=> regulator_off == $past(bus_wr_data[20]))
    else $error("regulator off did not follow write");
  a_algo_readback: assert property (
    (s_algo1_write ##1 s_algo1_read) |=>
      bus_rd_data[30:0] == $past(bus_wr_data[30:0], 2))
    else $error("first algorithm word did not read back");
  a_unmapped_zero: assert property (
    (bus_rd_en && sel == dacr_pkg::SEL_NONE) |=> bus_rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_algo_top_zero: assert property (
    s_algo1_read |=> !bus_rd_data[31])
    else $error("bit 31 of first algorithm word not zero");
  a_reserved_zero: assert property (
    s_gd2_read |=> !bus_rd_data[25] && bus_rd_data[16:0] == 17'h0)
    else $error("reserved gate word bits not zero");
  a_read_one_cycle: assert property (
    !bus_rd_en |=> bus_rd_data == 32'h0)
    else $error("read data outside its cycle");
  // The limit select output follows the written bit in the cycle after the write.
  a_limit_sel_follows: assert property (
    wr_gd2 |=> regulator_limit_select == $past(bus_wr_data[dacr_pkg::LIMIT_BIT]))
    else $error("limit select did not follow write");
  a_vsel_readback: assert property (
    (wr_gd2 ##1 s_gd2_read) |=>
      bus_rd_data[22:21] == $past(bus_wr_data[22:21], 2))
    else $error("voltage code did not read back");
  a_minon_readback: assert property (
    (wr_gd2 ##1 s_gd2_read) |=>
      bus_rd_data[19:17] == $past(bus_wr_data[19:17], 2))
    else $error("on-time code did not read back");
  // Unmapped writes must leave both algorithm words alone.
  a_unmapped_write: assert property (
    (bus_wr_en && sel == dacr_pkg::SEL_NONE) |=>
      $stable(algorithm_config_one_bits) && $stable(algorithm_config_two_bits))
    else $error("unmapped write changed an algorithm word");
  a_algo2_readback: assert property (
    (wr_algo2 ##1 s_algo2_read) |=>
      bus_rd_data == {22'h0, $past(bus_wr_data[9:0], 2)})
    else $error("second algorithm word did not read back");
  a_algo_one_follows: assert property (
    wr_algo1 |=> algorithm_config_one_bits == $past(bus_wr_data[30:0]))
    else $error("first algorithm word did not follow write");

endmodule : dacr_regs
`default_nettype wire

// file: testbench/tb_driver_and_algo_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Self-checking bench for the configuration bank.
// Reads are noted in a queue and a monitor checks the answer a cycle later.
module tb_driver_and_algo_config_regs;
  // Clock, reset and register bus driven by the bench.
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] bus_addr = 10'h000;
  logic [31:0] bus_wr_data = 32'h0000_0000;
  logic bus_wr_en = 1'b0;
  logic bus_rd_en = 1'b0;
  logic [1:0] slew_rate_code = 2'h2;
  // Outputs of the bank.
  logic [31:0] bus_rd_data;
  logic parity_bit, delay_comp_en, regulator_sequencing_off, regulator_limit_select;
  logic regulator_off, edge_rate_reserved;
  logic [7:0] delay_target_cycles;
  logic [6:0] min_on_cycles;
  logic [9:0] regulator_limit_ma;
  logic [12:0] regulator_voltage_mv;
  logic [30:0] algorithm_config_one_bits;
  logic [9:0] algorithm_config_two_bits;
  // Counters for the verdict.
  int miscompares = 0;
  int num_checks = 0;
  // Expected read data, oldest first, and a flag for a strobe taken at the last edge.
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;

  // ======================================================================
  // Clock at 50 MHz.
  always #(dacr_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  dacr_regs i_dacr_regs (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wr_data(bus_wr_data), .bus_wr_en(bus_wr_en), .bus_rd_en(bus_rd_en),
    .bus_rd_data(bus_rd_data), .slew_rate_code(slew_rate_code),
    .parity_bit(parity_bit), .delay_comp_en(delay_comp_en),
    .delay_target_cycles(delay_target_cycles), .min_on_cycles(min_on_cycles),
    .regulator_sequencing_off(regulator_sequencing_off),
    .regulator_limit_select(regulator_limit_select),
    .regulator_limit_ma(regulator_limit_ma), .regulator_voltage_mv(regulator_voltage_mv),
    .regulator_off(regulator_off), .edge_rate_reserved(edge_rate_reserved),
    .algorithm_config_one_bits(algorithm_config_one_bits),
    .algorithm_config_two_bits(algorithm_config_two_bits)
  );

  // ======================================================================
  // Compare one value and report a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One write cycle; strobes are set explicitly so requests may follow back to back.
  task automatic bus_write(input logic [9:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wr_data <= d;
    bus_wr_en <= 1'b1;
    bus_rd_en <= 1'b0;
    @(posedge ref_clk);
  endtask : bus_write

  // One read cycle; the expected answer is noted for the monitor.
  task automatic bus_read(input logic [9:0] a, input logic [31:0] e);
    bus_addr <= a;
    bus_rd_en <= 1'b1;
    bus_wr_en <= 1'b0;
    exp_q.push_back(e);
    @(posedge ref_clk);
  endtask : bus_read

  // Idle cycles with both strobes low.
  task automatic idle(input int n);
    for (int k = 0; k < n; k++) begin
      bus_wr_en <= 1'b0;
      bus_rd_en <= 1'b0;
      @(posedge ref_clk);
    end
  endtask : idle

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // ======================================================================
  // Monitor: read data stand only in the cycle after the strobe, zero otherwise.
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      if (exp_q.size() > 0) begin
        check("bus_rd_data", exp_q.pop_front(), bus_rd_data);
      end else begin
        check("read queue", 32'h0000_0001, 32'h0000_0000);
      end
    end else if (reset_n) begin
      check("idle bus_rd_data", 32'h0000_0000, bus_rd_data);
    end
    rd_seen = bus_rd_en;
  end

  // ======================================================================
  // Main sequence.
  initial begin
    int dly;
    int mon;
    logic [1:0] s;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] g;
    void'($urandom(32'h87A9C8DA));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(1);
    #1;
    // Reset state of the fields and the first decoder load.
    check("sequencing_off", 32'h0000_0001, 32'(regulator_sequencing_off));
    check("voltage_mv", dacr_pkg::BUCK_MV[1], 32'(regulator_voltage_mv));
    check("limit_ma", dacr_pkg::LIMIT_MA[0], 32'(regulator_limit_ma));
    check("delay_cycles", (dacr_pkg::AUTO_DLY_125_NS + 19) / 20, 32'(delay_target_cycles));
    bus_read(10'h2B8, 32'h0120_0000);
    bus_read(10'h280, 32'h0000_0000);
    bus_read(10'h288, 32'h0000_0000);
    // Writing zero leaves the clear-on-one bit set; a one clears it for good.
    bus_write(10'h2B8, 32'h0000_0000);
    bus_read(10'h2B8, 32'h0100_0000);
    bus_write(10'h2B8, 32'hFFFF_FFFF);
    bus_read(10'h2B8, 32'hFCFE_0000);
    bus_write(10'h2B8, 32'h0100_0000);
    bus_read(10'h2B8, 32'h0000_0000);
    // Every delay code with random other fields, reserved bits and edge rate.
    for (int i = 0; i < 16; i++) begin
      d = $urandom;
      d[29:26] = 4'(i);
      // Sweep the voltage and on-time codes as well; pass 9 takes the automatic on-time at 200 V/us.
      d[22:21] = 2'(i);
      d[19:17] = 3'(i);
      s = (i == 9) ? 2'h3 : 2'($urandom);
      slew_rate_code <= s;
      bus_write(10'h2B8, d);
      bus_read(10'h2B8, d & 32'hFCFE_0000);
      #1;
      dly = (d[29:26] == 4'h0) ? ((s == 2'h3) ? dacr_pkg::AUTO_DLY_200_NS :
            dacr_pkg::AUTO_DLY_125_NS) : 200 * (int'(d[29:26]) + 1);
      mon = (d[19:17] == 3'h1) ? ((s == 2'h3) ? dacr_pkg::AUTO_MINON_200_NS :
            dacr_pkg::AUTO_MINON_125_NS) : dacr_pkg::MINON_NS[d[19:17]];
      check("delay_cycles", (dly + 19) / 20, 32'(delay_target_cycles));
      check("min_on_cycles", (mon + 19) / 20, 32'(min_on_cycles));
      check("voltage_mv", dacr_pkg::BUCK_MV[d[22:21]], 32'(regulator_voltage_mv));
      check("limit_ma", dacr_pkg::LIMIT_MA[d[23]], 32'(regulator_limit_ma));
      check("limit_select", 32'(d[23]), 32'(regulator_limit_select));
      check("comp_en", 32'(d[30]), 32'(delay_comp_en));
      check("regulator_off", 32'(d[20]), 32'(regulator_off));
      check("parity_bit", 32'(d[31]), 32'(parity_bit));
      check("edge_rate_reserved", 32'(s < 2'h2), 32'(edge_rate_reserved));
      check("sequencing_off", 32'h0000_0000, 32'(regulator_sequencing_off));
      g = d & 32'hFCFE_0000;
    end
    // Algorithm words with random data, each read right after its own write.
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      e = $urandom;
      bus_write(10'h280, d);
      bus_read(10'h280, d & 32'h7FFF_FFFF);
      bus_write(10'h288, e);
      bus_read(10'h288, e & 32'h0000_03FF);
      #1;
      check("algo_one_bits", 32'(d[30:0]), 32'(algorithm_config_one_bits));
      check("algo_two_bits", 32'(e[9:0]), 32'(algorithm_config_two_bits));
    end
    // Misaligned and unmapped places ignore writes and read zero.
    // reserved algorithm offsets only read
    bus_write(10'h2B9, 32'hFFFF_FFFF);
    bus_write(10'h100, 32'hFFFF_FFFF);
    bus_write(10'h3FC, 32'hFFFF_FFFF);
    bus_read(10'h284, 32'h0000_0000);
    bus_read(10'h290, 32'h0000_0000);
    bus_read(10'h281, 32'h0000_0000);
    bus_read(10'h280, d & 32'h7FFF_FFFF);
    bus_read(10'h2B8, g);
    idle(2);
    // Reset raised just after an edge acts at once, before the next edge.
    reset_n <= 1'b0;
    #1;
    check("sequencing_off", 32'h0000_0001, 32'(regulator_sequencing_off));
    check("algo_one_bits", 32'h0000_0000, 32'(algorithm_config_one_bits));
    check("comp_en", 32'h0000_0000, 32'(delay_comp_en));
    @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(1);
    bus_read(10'h2B8, 32'h0120_0000);
    idle(1);
    // Bounded drain of outstanding reads before the verdict.
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) begin
      @(posedge ref_clk);
    end
    if (exp_q.size() > 0) begin
      miscompares++;
    end
    print_verdict();
  end
endmodule : tb_driver_and_algo_config_regs
`default_nettype wire
